// >>> inc/tsf_pkg.sv
// constants for the timer channel status flags
// assumes one system clock, synchronous active-high reset
package tsf_pkg;

  // ****************************************
  // geometry
  // ****************************************
  localparam int CHAN_NUM = 6;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;

  // ****************************************
  // register map, one byte register per channel at base + channel
  // ****************************************
  localparam logic [2:0] CHAN_STATUS_BASE = 3'h0;
  localparam logic [2:0] CHAN_STATUS_LAST = 3'h5;

  // ****************************************
  // channel status field positions
  // ****************************************
  localparam int DIR_BIT = 7;
  localparam int RSV6_BIT = 6;
  localparam int UNF_BIT = 5;
  localparam int OVF_BIT = 4;
  localparam int CCD_BIT = 3;
  localparam int CCC_BIT = 2;

  // ****************************************
  // reset and fixed read values
  // ****************************************
  localparam logic FLAG_RST = 1'b0;
  localparam logic DIR_RSV_VAL = 1'b1;
  localparam logic RSV6_VAL = 1'b1;
  localparam logic RSV_ZERO_VAL = 1'b0;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_VAL = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_MIN = 16'h0000;

endpackage : tsf_pkg

// >>> core/tsf_status.sv
// six channel status registers of a 16-bit timer unit
// assumes counter, compare/capture and transfer controller logic on sys_clk
//
// What this block does
// - channels 1,2,4,5 show count direction in bit 7: 1 up, 0 down
// - channels 0 and 3 read bit 7 as 1, writes ignored
// - bit 6 reads 1 in every channel, writes ignored
// - channels 1,2,4,5 in phase mode set underflow on 0000 to ffff
// - underflow cleared only by writing 0 after reading it as 1
// - channels 0 and 3 read bit 5 as 0, writes ignored
// - every channel sets overflow flag on counter wrap ffff to 0000
// - overflow cleared only by a 0 write after reading 1; 1 ignored
// - channels 0,3 compare mode: flag d set when counter equals reg d
// - channels 0,3 capture mode: flag d set on capture into reg d
// - flag d cleared by transfer controller start when disable select 0
// - flag d also cleared by a 0 write after reading 1
// - channels 1,2,4,5 read bit 3 as 0, writes ignored
// - channels 0,3 compare mode: flag c set when counter equals reg c
// - channels 0,3 capture mode: flag c set on capture into reg c
// - flag c cleared by transfer controller start when disable select 0
// - flag c also cleared by a 0 write after reading 1; 1 ignored
// - channels 1,2,4,5 read bit 2 as 0, writes ignored
// - one 8-bit status register per channel, six channels
// - each request is raised only while its flag is 1 and its enable was 1 the cycle before
//
// Implementation choices: the plain strobed port and the address map.
module tsf_status (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [5:0] cnt_up,
  input wire logic [5:0] phase_mode,
  input wire logic [5:0][15:0] chan_cnt,
  input wire logic [1:0][15:0] gen_reg_c,
  input wire logic [1:0][15:0] gen_reg_d,
  input wire logic [1:0] capture_mode_c,
  input wire logic [1:0] capture_mode_d,
  input wire logic [1:0] capture_c,
  input wire logic [1:0] capture_d,
  input wire logic [1:0] dtc_start_c,
  input wire logic [1:0] dtc_start_d,
  input wire logic [1:0] disable_sel_c,
  input wire logic [1:0] disable_sel_d,
  input wire logic [5:0] overflow_irq_enable,
  input wire logic [5:0] underflow_irq_enable,
  input wire logic [1:0] capcomp_irq_enable_c,
  input wire logic [1:0] capcomp_irq_enable_d,
  output logic [5:0] overflow_irq,
  output logic [5:0] underflow_irq,
  output logic [1:0] capcomp_irq_c,
  output logic [1:0] capcomp_irq_d
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [5:0][15:0] prev_cnt;
    logic [5:0] unf;
    logic [5:0] ovf;
    logic [1:0] ccc;
    logic [1:0] ccd;
    logic [5:0] unf_arm;
    logic [5:0] ovf_arm;
    logic [1:0] ccc_arm;
    logic [1:0] ccd_arm;
    logic [7:0] rdata;
    logic [5:0] ovf_irq;
    logic [5:0] unf_irq;
    logic [1:0] ccc_irq;
    logic [1:0] ccd_irq;
  } tsf_state_t;

  tsf_state_t st_ff;
  tsf_state_t nxt_st;

  // ****************************************
  // helpers
  // ****************************************
  // channels 0 and 3 own general registers c and d
  function automatic logic has_cd(input int ch);
    has_cd = (ch == 0) || (ch == 3);
  endfunction

  // index of a c/d channel in the two-entry vectors
  function automatic int cd_idx(input int ch);
    cd_idx = (ch == 3) ? 1 : 0;
  endfunction

  // flag update: set wins, else clear, else hold
  function automatic logic flag_upd(input logic cur, input logic set, input logic clr);
    flag_upd = set | (cur & ~clr);
  endfunction

  localparam logic [15:0] CNT_RST_L = tsf_pkg::CNT_RST;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic hit;
    logic rd_hit;
    logic wr_hit;
    logic [15:0] cnt;
    logic [15:0] prv;
    logic moved;
    logic s_ovf;
    logic s_unf;
    logic s_c;
    logic s_d;
    logic clr;
    logic [7:0] rb;
    int k;
    hit = 1'b0;
    rd_hit = 1'b0;
    wr_hit = 1'b0;
    cnt = CNT_RST_L;
    prv = CNT_RST_L;
    moved = 1'b0;
    s_ovf = 1'b0;
    s_unf = 1'b0;
    s_c = 1'b0;
    s_d = 1'b0;
    clr = 1'b0;
    rb = tsf_pkg::UNMAPPED_VAL;
    k = 0;
    nxt_st = st_ff;
    for (int ch = 0; ch < tsf_pkg::CHAN_NUM; ch++) begin
      hit = (addr == 3'(ch + int'(tsf_pkg::CHAN_STATUS_BASE)));
      rd_hit = rd && hit;
      wr_hit = wr && hit;
      cnt = chan_cnt[ch];
      prv = st_ff.prev_cnt[ch];
      moved = (cnt != prv);
      nxt_st.prev_cnt[ch] = cnt;
      // overflow on every channel
      s_ovf = (prv == tsf_pkg::CNT_MAX) && (cnt == tsf_pkg::CNT_MIN);
      clr = wr_hit && !wdata[tsf_pkg::OVF_BIT] && st_ff.ovf_arm[ch];
      nxt_st.ovf[ch] = flag_upd(st_ff.ovf[ch], s_ovf, clr);
      nxt_st.ovf_arm[ch] = (st_ff.ovf_arm[ch] | (rd_hit & st_ff.ovf[ch]))
        & nxt_st.ovf[ch] & ~s_ovf;
      nxt_st.ovf_irq[ch] = nxt_st.ovf[ch] & overflow_irq_enable[ch];
      if (has_cd(ch)) begin
        k = cd_idx(ch);
        // underflow bit is reserved here
        nxt_st.unf[ch] = tsf_pkg::FLAG_RST;
        nxt_st.unf_arm[ch] = 1'b0;
        nxt_st.unf_irq[ch] = 1'b0;
        s_c = capture_mode_c[k] ? capture_c[k]
          : (moved && cnt == gen_reg_c[k]);
        s_d = capture_mode_d[k] ? capture_d[k]
          : (moved && cnt == gen_reg_d[k]);
        clr = (dtc_start_c[k] && !disable_sel_c[k])
          || (wr_hit && !wdata[tsf_pkg::CCC_BIT] && st_ff.ccc_arm[k]);
        nxt_st.ccc[k] = flag_upd(st_ff.ccc[k], s_c, clr);
        nxt_st.ccc_arm[k] = (st_ff.ccc_arm[k] | (rd_hit & st_ff.ccc[k]))
          & nxt_st.ccc[k] & ~s_c;
        clr = (dtc_start_d[k] && !disable_sel_d[k])
          || (wr_hit && !wdata[tsf_pkg::CCD_BIT] && st_ff.ccd_arm[k]);
        nxt_st.ccd[k] = flag_upd(st_ff.ccd[k], s_d, clr);
        nxt_st.ccd_arm[k] = (st_ff.ccd_arm[k] | (rd_hit & st_ff.ccd[k]))
          & nxt_st.ccd[k] & ~s_d;
        nxt_st.ccc_irq[k] = nxt_st.ccc[k] & capcomp_irq_enable_c[k];
        nxt_st.ccd_irq[k] = nxt_st.ccd[k] & capcomp_irq_enable_d[k];
      end else begin
        s_unf = phase_mode[ch] && (prv == tsf_pkg::CNT_MIN)
          && (cnt == tsf_pkg::CNT_MAX);
        clr = wr_hit && !wdata[tsf_pkg::UNF_BIT] && st_ff.unf_arm[ch];
        nxt_st.unf[ch] = flag_upd(st_ff.unf[ch], s_unf, clr);
        nxt_st.unf_arm[ch] = (st_ff.unf_arm[ch] | (rd_hit & st_ff.unf[ch]))
          & nxt_st.unf[ch] & ~s_unf;
        nxt_st.unf_irq[ch] = nxt_st.unf[ch] & underflow_irq_enable[ch];
      end
      // read byte of this channel
      if (hit) begin
        rb = 8'h00;
        rb[tsf_pkg::RSV6_BIT] = tsf_pkg::RSV6_VAL;
        rb[tsf_pkg::OVF_BIT] = st_ff.ovf[ch];
        if (has_cd(ch)) begin
          rb[tsf_pkg::DIR_BIT] = tsf_pkg::DIR_RSV_VAL;
          rb[tsf_pkg::UNF_BIT] = tsf_pkg::RSV_ZERO_VAL;
          rb[tsf_pkg::CCD_BIT] = st_ff.ccd[cd_idx(ch)];
          rb[tsf_pkg::CCC_BIT] = st_ff.ccc[cd_idx(ch)];
        end else begin
          rb[tsf_pkg::DIR_BIT] = cnt_up[ch];
          rb[tsf_pkg::UNF_BIT] = st_ff.unf[ch];
          rb[tsf_pkg::CCD_BIT] = tsf_pkg::RSV_ZERO_VAL;
          rb[tsf_pkg::CCC_BIT] = tsf_pkg::RSV_ZERO_VAL;
        end
      end
    end
    // read data stands one cycle, zero otherwise
    nxt_st.rdata = rd ? rb : tsf_pkg::RDATA_RST;
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata = st_ff.rdata;
  assign overflow_irq = st_ff.ovf_irq;
  assign underflow_irq = st_ff.unf_irq;
  assign capcomp_irq_c = st_ff.ccc_irq;
  assign capcomp_irq_d = st_ff.ccd_irq;

  // ****************************************
  // checks
  // ****************************************
  a_ovf_wrap_set: assert property (@(posedge sys_clk) disable iff (rst)
    (st_ff.prev_cnt[1] == 16'hffff && chan_cnt[1] == 16'h0000) |=> st_ff.ovf[1])
    else $error("overflow flag not set on wrap");

  a_unf_wrap_set: assert property (@(posedge sys_clk) disable iff (rst)
    (phase_mode[2] && st_ff.prev_cnt[2] == 16'h0000 && chan_cnt[2] == 16'hffff)
    |=> st_ff.unf[2])
    else $error("underflow flag not set on wrap");

  a_rsv_flags_zero: assert property (@(posedge sys_clk) disable iff (rst)
    !st_ff.unf[0] && !st_ff.unf[3] && !underflow_irq[0] && !underflow_irq[3])
    else $error("reserved underflow bit of channel 0 or 3 set");

  a_rd_rsv_bits: assert property (@(posedge sys_clk) disable iff (rst)
    (rd && addr == 3'h0) |=> (rdata[7:5] == 3'b110 && rdata[1:0] == 2'b00))
    else $error("reserved bits of channel 0 read wrong");

  a_rd_dir_bit: assert property (@(posedge sys_clk) disable iff (rst)
    (rd && addr == 3'h1) |=> (rdata[7] == $past(cnt_up[1]) && rdata[6]
    && rdata[3:2] == 2'b00))
    else $error("direction or reserved bits of channel 1 wrong");

  a_wr_one_keeps: assert property (@(posedge sys_clk) disable iff (rst)
    (wr && addr == 3'h1 && wdata[4] && st_ff.ovf[1]) |=> st_ff.ovf[1])
    else $error("write of 1 cleared overflow flag");

  a_clr_needs_read: assert property (@(posedge sys_clk) disable iff (rst)
    (st_ff.ovf[1] && !st_ff.ovf_arm[1] && !rd) ##1 (wr && addr == 3'h1 && !wdata[4])
    |=> st_ff.ovf[1])
    else $error("overflow cleared without prior read of 1");

  a_rd_then_clr: assert property (@(posedge sys_clk) disable iff (rst)
    (rd && addr == 3'h0 && st_ff.ccd[0] && !capture_d[0] && capture_mode_d[0])
    ##1 (!capture_d[0] && capture_mode_d[0] && !rd && !wr)
    ##1 (wr && addr == 3'h0 && !wdata[3] && !capture_d[0] && capture_mode_d[0])
    |=> !st_ff.ccd[0])
    else $error("flag d not cleared by read 1 then write 0");

  a_dtc_clears_c: assert property (@(posedge sys_clk) disable iff (rst)
    (dtc_start_c[0] && !disable_sel_c[0] && (capture_mode_c[0] ? !capture_c[0]
    : (chan_cnt[0] == st_ff.prev_cnt[0] || chan_cnt[0] != gen_reg_c[0])))
    |=> !st_ff.ccc[0])
    else $error("transfer start did not clear flag c");

  a_set_wins_clr: assert property (@(posedge sys_clk) disable iff (rst)
    (capture_mode_c[1] && capture_c[1] && dtc_start_c[1]) |=> st_ff.ccc[1])
    else $error("clear beat set of flag c");

  a_irq_gated: assert property (@(posedge sys_clk) disable iff (rst)
    overflow_irq[1] |-> (st_ff.ovf[1] && $past(overflow_irq_enable[1])))
    else $error("overflow request without flag and enable");

  // ****************************************
  // read layout and flag checks
  // ****************************************
  a_rd_unmapped_zero: assert property (@(posedge sys_clk) disable iff (rst)
    (rd && addr > 3'h5)
    |=> rdata == 8'h00)
    else $error("unmapped read returned nonzero");

  a_rdata_one_cycle: assert property (@(posedge sys_clk) disable iff (rst)
    !rd
    |=> rdata == 8'h00)
    else $error("read data stood without a read");

  a_rd_ch2_rsv: assert property (@(posedge sys_clk) disable iff (rst)
    (rd && addr == 3'h2)
    |=> (rdata[6] && rdata[3:0] == 4'h0))
    else $error("reserved bits of channel 2 read wrong");

  a_rd_ch3_rsv: assert property (@(posedge sys_clk) disable iff (rst)
    (rd && addr == 3'h3)
    |=> (rdata[7:5] == 3'b110 && rdata[1:0] == 2'b00))
    else $error("reserved bits of channel 3 read wrong");

  a_rd_ch4_dir: assert property (@(posedge sys_clk) disable iff (rst)
    (rd && addr == 3'h4)
    |=> (rdata[7] == $past(cnt_up[4]) && rdata[3:2] == 2'b00))
    else $error("direction or reserved bits of channel 4 wrong");

  a_cmp_sets_c: assert property (@(posedge sys_clk) disable iff (rst)
    (!capture_mode_c[0] && chan_cnt[0] != st_ff.prev_cnt[0] && chan_cnt[0] == gen_reg_c[0])
    |=> st_ff.ccc[0])
    else $error("compare match did not set flag c");

  a_cmp_sets_d: assert property (@(posedge sys_clk) disable iff (rst)
    (!capture_mode_d[0] && chan_cnt[0] != st_ff.prev_cnt[0] && chan_cnt[0] == gen_reg_d[0])
    |=> st_ff.ccd[0])
    else $error("compare match did not set flag d");

  a_cap_sets_c: assert property (@(posedge sys_clk) disable iff (rst)
    (capture_mode_c[0] && capture_c[0])
    |=> st_ff.ccc[0])
    else $error("capture did not set flag c");

  a_cap_sets_d: assert property (@(posedge sys_clk) disable iff (rst)
    (capture_mode_d[0] && capture_d[0])
    |=> st_ff.ccd[0])
    else $error("capture did not set flag d");

  a_dtc_clears_d: assert property (@(posedge sys_clk) disable iff (rst)
    (dtc_start_d[1] && !disable_sel_d[1] && (capture_mode_d[1] ? !capture_d[1]
    : (chan_cnt[3] == st_ff.prev_cnt[3] || chan_cnt[3] != gen_reg_d[1])))
    |=> !st_ff.ccd[1])
    else $error("transfer start did not clear flag d");

  a_dis_keeps_c: assert property (@(posedge sys_clk) disable iff (rst)
    (dtc_start_c[0] && disable_sel_c[0] && st_ff.ccc[0] && !wr)
    |=> st_ff.ccc[0])
    else $error("disabled transfer start cleared flag c");

  a_unf_one_keeps: assert property (@(posedge sys_clk) disable iff (rst)
    (wr && addr == 3'h2 && wdata[5] && st_ff.unf[2])
    |=> st_ff.unf[2])
    else $error("write of 1 cleared underflow flag");

  a_ccd_one_keeps: assert property (@(posedge sys_clk) disable iff (rst)
    (wr && addr == 3'h0 && wdata[3] && st_ff.ccd[0] && !dtc_start_d[0])
    |=> st_ff.ccd[0])
    else $error("write of 1 cleared flag d");

  a_ccc_one_keeps: assert property (@(posedge sys_clk) disable iff (rst)
    (wr && addr == 3'h3 && wdata[2] && st_ff.ccc[1] && !dtc_start_c[1])
    |=> st_ff.ccc[1])
    else $error("write of 1 cleared flag c");

  a_ccirq_gated: assert property (@(posedge sys_clk) disable iff (rst)
    capcomp_irq_c[0]
    |-> (st_ff.ccc[0] && $past(capcomp_irq_enable_c[0])))
    else $error("flag c request without flag and enable");

  a_unfirq_gated: assert property (@(posedge sys_clk) disable iff (rst)
    underflow_irq[2]
    |-> (st_ff.unf[2] && $past(underflow_irq_enable[2])))
    else $error("underflow request without flag and enable");

endmodule // tsf_status

// >>> verif/test_timer_channel_status_flags.sv
// self-checking bench for the six channel status registers
// assumes tsf_status alone on sys_clk; bench drives every input itself
module test_timer_channel_status_flags;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // stimulus and model state
  // ****************************************
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [5:0] cnt_up = 6'h00, phase_mode = 6'h00, ovf_en = 6'h00, unf_en = 6'h00;
  logic [5:0][15:0] chan_cnt = '0;
  logic [1:0][15:0] gen_reg_c = {16'h4000, 16'h4000};
  logic [1:0][15:0] gen_reg_d = {16'h4000, 16'h4000};
  logic [1:0] cap_mode_c = '0, cap_mode_d = '0, cap_c = '0, cap_d = '0;
  logic [1:0] dtc_c = '0, dtc_d = '0, dis_c = '0, dis_d = '0, cc_en_c = '0, cc_en_d = '0;
  logic [5:0] ovf_irq, unf_irq;
  logic [1:0] cc_irq_c, cc_irq_d;
  logic [7:0] flg [6];
  logic [7:0] arm [6];
  logic [15:0] v;
  int n_errors = 0;
  int n_compared = 0;
  int ch;

  always #2 sys_clk = ~sys_clk;

  tsf_status dut (
    .sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .cnt_up(cnt_up), .phase_mode(phase_mode), .chan_cnt(chan_cnt),
    .gen_reg_c(gen_reg_c), .gen_reg_d(gen_reg_d), .capture_mode_c(cap_mode_c),
    .capture_mode_d(cap_mode_d), .capture_c(cap_c), .capture_d(cap_d),
    .dtc_start_c(dtc_c), .dtc_start_d(dtc_d), .disable_sel_c(dis_c), .disable_sel_d(dis_d),
    .overflow_irq_enable(ovf_en), .underflow_irq_enable(unf_en),
    .capcomp_irq_enable_c(cc_en_c), .capcomp_irq_enable_d(cc_en_d),
    .overflow_irq(ovf_irq), .underflow_irq(unf_irq),
    .capcomp_irq_c(cc_irq_c), .capcomp_irq_d(cc_irq_d)
  );

  // ****************************************
  // expectations, bus cycles and checks
  // ****************************************
  function automatic logic [7:0] exp_reg(input int a);
    if (a > 5) return 8'h00;
    if (a == 0 || a == 3) return 8'hc0 | flg[a];
    return {cnt_up[a], 1'b1, 6'h00} | flg[a];
  endfunction

  function automatic logic [15:0] exp_irq();
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 6; i++) begin
      r[i] = flg[i][4] & ovf_en[i];
      r[6+i] = flg[i][5] & unf_en[i];
    end
    for (int k = 0; k < 2; k++) begin
      r[12+k] = flg[3*k][2] & cc_en_c[k];
      r[14+k] = flg[3*k][3] & cc_en_d[k];
    end
    return r;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input int a);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= a[2:0];
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, exp_reg(a)});
    if (a < 6) arm[a] = flg[a];
  endtask

  task automatic wr_reg(input int a, input logic [7:0] w);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a[2:0];
    wdata <= w;
    @(posedge sys_clk);
    wr <= 1'b0;
    if (a < 6) begin
      flg[a] &= ~(arm[a] & ~w);
      arm[a] &= flg[a];
    end
  endtask

  task automatic idle();
    repeat (3) @(posedge sys_clk);
    #1 chk({cc_irq_d, cc_irq_c, unf_irq, ovf_irq}, exp_irq());
  endtask

  task automatic cnt(input int c, input logic [15:0] val);
    @(posedge sys_clk);
    chan_cnt[c] <= val;
    idle();
  endtask

  task automatic hit(input int c, input int b);
    flg[c][b] = 1'b1;
    arm[c][b] = 1'b0;
  endtask

  task automatic finish_test();
    if (n_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    finish_test();
  end

  initial begin
    for (int i = 0; i < 6; i++) begin
      flg[i] = 8'h00;
      arm[i] = 8'h00;
    end
    void'($urandom(32'hd721));
    cnt_up = 6'($urandom);
    ovf_en = 6'($urandom);
    unf_en = 6'($urandom);
    cc_en_c = 2'($urandom);
    cc_en_d = 2'($urandom);
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      wr_reg(a, 8'hff);
      rd_chk(a);
    end
    for (ch = 0; ch < 6; ch++) begin
      cnt(ch, 16'hffff);
      hit(ch, 4);
      cnt(ch, 16'h0000);
      wr_reg(ch, 8'h00);
      rd_chk(ch);
      wr_reg(ch, 8'hff);
      wr_reg(ch, 8'h00);
      rd_chk(ch);
      idle();
    end
    phase_mode <= 6'h3f;
    for (ch = 0; ch < 6; ch++) begin
      if (ch != 0 && ch != 3) hit(ch, 5);
      cnt(ch, 16'hffff);
      rd_chk(ch);
      wr_reg(ch, 8'hff);
      wr_reg(ch, 8'h00);
      rd_chk(ch);
      cnt(ch, 16'h8000);
      cnt(ch, 16'h0000);
    end
    for (int k = 0; k < 2; k++) begin
      ch = 3 * k;
      v = 16'($urandom_range(16'h1000, 16'h3fff));
      @(posedge sys_clk);
      gen_reg_c[k] <= v;
      gen_reg_d[k] <= v + 16'h1;
      hit(ch, 2);
      cnt(ch, v);
      hit(ch, 3);
      cnt(ch, v + 16'h1);
      rd_chk(ch);
      @(posedge sys_clk);
      dis_c[k] <= 1'b1;
      dis_d[k] <= 1'b1;
      dtc_c[k] <= 1'b1;
      dtc_d[k] <= 1'b1;
      @(posedge sys_clk);
      dtc_c[k] <= 1'b0;
      dtc_d[k] <= 1'b0;
      idle();
      rd_chk(ch);
      @(posedge sys_clk);
      dis_c[k] <= 1'b0;
      dis_d[k] <= 1'b0;
      dtc_c[k] <= 1'b1;
      dtc_d[k] <= 1'b1;
      @(posedge sys_clk);
      dtc_c[k] <= 1'b0;
      dtc_d[k] <= 1'b0;
      flg[ch][3:2] = 2'b00;
      arm[ch][3:2] = 2'b00;
      idle();
      rd_chk(ch);
      @(posedge sys_clk);
      cap_mode_c[k] <= 1'b1;
      cap_mode_d[k] <= 1'b1;
      cap_c[k] <= 1'b1;
      cap_d[k] <= 1'b1;
      dtc_c[k] <= 1'b1;
      dtc_d[k] <= 1'b1;
      @(posedge sys_clk);
      cap_c[k] <= 1'b0;
      cap_d[k] <= 1'b0;
      dtc_c[k] <= 1'b0;
      dtc_d[k] <= 1'b0;
      hit(ch, 2);
      hit(ch, 3);
      idle();
      rd_chk(ch);
      wr_reg(ch, 8'hff);
      rd_chk(ch);
      wr_reg(ch, 8'h00);
      rd_chk(ch);
    end
    finish_test();
  end
endmodule // test_timer_channel_status_flags
